// >>> rph_fifo.sv
`timescale 1ns/1ps
package rph_pkg;
   localparam int FIFO_DEPTH = 64;
   localparam logic [7:0] CMD_TX_WRITE = 8'h66;
   localparam logic [7:0] CMD_RX_READ = 8'h77;
   localparam int FRST_TX_BIT = 0;
   localparam int FRST_RX_BIT = 1;
   localparam logic [7:0] PREAMBLE_BYTE = 8'haa;
   localparam logic [15:0] CRC_POLY = 16'h1021;
   localparam logic [15:0] CRC_SEED = 16'hffff;
   localparam logic [8:0] PN9_SEED = 9'h1ff;
   localparam int PN9_TAP = 5;
   localparam logic [2:0] LAST_BIT = 3'h7;
   localparam int BIT_DIV_DEFAULT = 50;

   typedef struct packed {
      logic preamble;
      logic sync;
      logic header;
      logic length;
      logic crc;
   } rph_fields_s;

   typedef struct packed {
      logic whiten;
      logic manchester;
   } rph_coding_s;

   typedef struct packed {
      logic ovf_rx;
      logic ovf_tx;
      logic crc_err;
      logic packet_good_flag;
      logic sync_ok;
      logic pre_valid;
      logic event_a;
      logic rx_afull;
      logic tx_aempty;
   } rph_events_s;

   typedef enum logic [7:0] {
      PS_IDLE = 8'h01,
      PS_PRE = 8'h02,
      PS_SYNC = 8'h04,
      PS_HDR = 8'h08,
      PS_LEN = 8'h10,
      PS_DATA = 8'h20,
      PS_CRC = 8'h40,
      PS_DONE = 8'h80
   } rph_state_e;

   // field order is fixed; skips every disabled field after s
   function automatic rph_state_e rph_fld_after(rph_state_e s, rph_fields_s f);
      if (s == PS_IDLE && f.preamble) return PS_PRE;
      if (s inside {PS_IDLE, PS_PRE} && f.sync) return PS_SYNC;
      if (s inside {PS_IDLE, PS_PRE, PS_SYNC} && f.header) return PS_HDR;
      if (s inside {PS_IDLE, PS_PRE, PS_SYNC, PS_HDR} && f.length) return PS_LEN;
      if (s inside {PS_IDLE, PS_PRE, PS_SYNC, PS_HDR, PS_LEN}) return PS_DATA;
      if (s == PS_DATA && f.crc) return PS_CRC;
      return PS_DONE;
   endfunction

   function automatic logic [15:0] rph_crc_step(logic [15:0] c, logic b);
      return {c[14:0], 1'b0} ^ ((c[15] ^ b) ? CRC_POLY : 16'h0000);
   endfunction

   function automatic logic [8:0] rph_pn_step(logic [8:0] p);
      return {p[0] ^ p[PN9_TAP], p[8:1]};
   endfunction
endpackage

module rph_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = rph_pkg::FIFO_DEPTH,
   localparam int AW = $clog2(DEPTH),
   localparam int CW = $clog2(DEPTH + 1)
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic clear,
   input wire logic wr_en,
   input wire logic [WIDTH-1:0] wr_data,
   input wire logic rd_en,
   output logic [WIDTH-1:0] head,
   output logic full,
   output logic empty,
   output logic [CW-1:0] count
);
   // depth must be a power of two so the pointers wrap by themselves
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
   logic [CW-1:0] cnt_r, cnt_nxt;
   logic do_wr, do_rd;

   assign full = (cnt_r == CW'(DEPTH));
   assign empty = (cnt_r == '0);
   assign count = cnt_r;
   assign head = mem[rp_r];
   assign do_wr = wr_en & ~full;
   assign do_rd = rd_en & ~empty;

   always_comb begin
      wp_nxt = wp_r;
      rp_nxt = rp_r;
      cnt_nxt = cnt_r;
      if (clear) begin
         wp_nxt = '0;
         rp_nxt = '0;
         cnt_nxt = '0;
      end else begin
         if (do_wr) wp_nxt = AW'(wp_r + 1'b1);
         if (do_rd) rp_nxt = AW'(rp_r + 1'b1);
         if (do_wr & ~do_rd) cnt_nxt = CW'(cnt_r + 1'b1);
         if (do_rd & ~do_wr) cnt_nxt = CW'(cnt_r - 1'b1);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end else begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
         cnt_r <= cnt_nxt;
      end
      if (do_wr && !clear) mem[wp_r] <= wr_data;
   end
endmodule

// >>> rph_top.sv
`timescale 1ns/1ps
module rph_top #(
   parameter int FIFO_DEPTH = rph_pkg::FIFO_DEPTH,
   parameter int BIT_DIV = rph_pkg::BIT_DIV_DEFAULT,
   localparam int CW = $clog2(FIFO_DEPTH + 1)
) (
   input wire logic REF_CLK,
   input wire logic RST,
   input wire logic HOST_WR,
   input wire logic HOST_RD,
   input wire logic [7:0] HOST_ADDR,
   input wire logic [7:0] HOST_WDATA,
   output logic [7:0] HOST_RDATA,
   input wire logic [1:0] FIFO_RESET,
   input wire logic [CW-1:0] TX_AE_LEVEL,
   input wire logic [CW-1:0] RX_AF_LEVEL,
   output logic [CW-1:0] TX_COUNT,
   output logic [CW-1:0] RX_COUNT,
   output logic TX_ALMOST_EMPTY,
   output logic RX_ALMOST_FULL,
   input wire logic TX_PH_EN,
   input wire logic RX_PH_EN,
   input wire rph_pkg::rph_fields_s TX_FIELDS,
   input wire rph_pkg::rph_fields_s RX_FIELDS,
   input wire rph_pkg::rph_coding_s TX_CODING,
   input wire rph_pkg::rph_coding_s RX_CODING,
   input wire logic [15:0] SYNC_WORD,
   input wire logic [7:0] HEADER_PATTERN,
   input wire logic [7:0] PRE_THRESH,
   input wire logic [7:0] PRE_BYTES,
   input wire logic [7:0] PKT_LEN,
   input wire logic TX_START,
   output logic TX_BUSY,
   output logic TX_DATA_OUT,
   input wire logic RX_ENABLE,
   input wire logic RX_DATA_IN,
   output rph_pkg::rph_events_s STATUS,
   input wire rph_pkg::rph_events_s INT_MASK,
   input wire rph_pkg::rph_events_s INT_CLEAR,
   output logic INTERRUPT_REQUEST_N
);
   import rph_pkg::*;
   localparam int DW = $clog2(BIT_DIV + 1);

   // bit-rate enable
   logic [DW-1:0] div_r, div_nxt;
   logic bit_en;
   assign bit_en = (div_r == DW'(BIT_DIV - 1));
   always_comb div_nxt = bit_en ? '0 : DW'(div_r + 1'b1);

   // host side and FIFOs
   logic tx_wr, tx_pop, tx_full, tx_empty, rx_push, rx_rd, rx_full, rx_empty;
   logic [7:0] tx_head, rx_head, rx_byte, rdata_r, rdata_nxt;
   logic [CW-1:0] tx_cnt, rx_cnt;
   assign tx_wr = HOST_WR && HOST_ADDR == CMD_TX_WRITE;
   assign rx_rd = HOST_RD && HOST_ADDR == CMD_RX_READ;
   always_comb rdata_nxt = (rx_rd && !rx_empty) ? rx_head : rdata_r;

   rph_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_txf (
      .clk(REF_CLK), .rst(RST), .clear(FIFO_RESET[FRST_TX_BIT]),
      .wr_en(tx_wr), .wr_data(HOST_WDATA), .rd_en(tx_pop),
      .head(tx_head), .full(tx_full), .empty(tx_empty), .count(tx_cnt));
   rph_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_rxf (
      .clk(REF_CLK), .rst(RST), .clear(FIFO_RESET[FRST_RX_BIT]),
      .wr_en(rx_push), .wr_data(rx_byte), .rd_en(rx_rd),
      .head(rx_head), .full(rx_full), .empty(rx_empty), .count(rx_cnt));

   assign TX_COUNT = tx_cnt;
   assign RX_COUNT = rx_cnt;
   assign TX_ALMOST_EMPTY = (tx_cnt <= TX_AE_LEVEL);
   assign RX_ALMOST_FULL = (rx_cnt >= RX_AF_LEVEL);
   assign HOST_RDATA = rdata_r;

   // transmit packet builder
   rph_fields_s tf;
   rph_coding_s tc;
   rph_state_e tst_r, tst_nxt, ldst;
   logic [7:0] tsh_r, tsh_nxt, tidx_r, tidx_nxt, tlen_r, tlen_nxt, ldidx, ldbyte;
   logic [2:0] tbc_r, tbc_nxt;
   logic [15:0] tcrc_r, tcrc_nxt;
   logic [8:0] tpn_r, tpn_nxt;
   logic tph_r, tph_nxt, twh_r, twh_nxt, tout_r, tout_nxt, tbusy_r, tbusy_nxt;
   logic tx_wbit, tx_chip, tx_adv, load, more, ev_sent;

   // packet handler off means raw payload with no coding
   assign tf = TX_PH_EN ? TX_FIELDS : '0;
   assign tc = TX_PH_EN ? TX_CODING : '0;
   assign tx_wbit = tsh_r[7] ^ (twh_r & tc.whiten & tpn_r[0]);
   assign tx_chip = (tc.manchester && tph_r) ? ~tx_wbit : tx_wbit;
   assign tx_adv = bit_en & (~tc.manchester | tph_r);

   always_comb begin
      tst_nxt = tst_r;
      tsh_nxt = tsh_r;
      tidx_nxt = tidx_r;
      tlen_nxt = tlen_r;
      tbc_nxt = tbc_r;
      tcrc_nxt = tcrc_r;
      tpn_nxt = tpn_r;
      tph_nxt = tph_r;
      twh_nxt = twh_r;
      tout_nxt = tout_r;
      tbusy_nxt = tbusy_r;
      ev_sent = 1'b0;
      tx_pop = 1'b0;
      load = 1'b0;
      more = 1'b0;
      ldst = PS_IDLE;
      ldidx = '0;
      if (tst_r == PS_IDLE) begin
         tph_nxt = 1'b0;
         if (TX_START) begin
            load = 1'b1;
            ldst = rph_fld_after(PS_IDLE, tf);
            tlen_nxt = 8'(tx_cnt);
            tcrc_nxt = CRC_SEED;
            tpn_nxt = PN9_SEED;
            tbc_nxt = '0;
            tbusy_nxt = 1'b1;
         end
      end else if (tst_r == PS_DONE) begin
         ev_sent = 1'b1;
         tst_nxt = PS_IDLE;
         tbusy_nxt = 1'b0;
      end else if (bit_en) begin
         tout_nxt = tx_chip;
         tph_nxt = tc.manchester & ~tph_r;
         if (tx_adv) begin
            tsh_nxt = {tsh_r[6:0], 1'b0};
            tbc_nxt = 3'(tbc_r + 1'b1);
            if (twh_r && tc.whiten) tpn_nxt = rph_pn_step(tpn_r);
            if (tst_r inside {PS_HDR, PS_LEN, PS_DATA})
               tcrc_nxt = rph_crc_step(tcrc_r, tsh_r[7]);
            if (tbc_r == LAST_BIT) begin
               load = 1'b1;
               unique case (tst_r)
                  PS_PRE: more = (8'(tidx_r + 1'b1) < PRE_BYTES);
                  PS_SYNC, PS_CRC: more = (tidx_r == '0);
                  PS_DATA: more = ~tx_empty;
                  default: more = 1'b0;
               endcase
               ldst = more ? tst_r : rph_fld_after(tst_r, tf);
               ldidx = more ? 8'(tidx_r + 1'b1) : '0;
            end
         end
      end
      if (ldst == PS_DATA && tx_empty) ldst = rph_fld_after(PS_DATA, tf);
      unique case (ldst)
         PS_PRE: ldbyte = PREAMBLE_BYTE;
         PS_SYNC: ldbyte = (ldidx == '0) ? SYNC_WORD[15:8] : SYNC_WORD[7:0];
         PS_HDR: ldbyte = HEADER_PATTERN;
         PS_LEN: ldbyte = tlen_nxt;
         PS_DATA: ldbyte = tx_head;
         PS_CRC: ldbyte = (ldidx == '0) ? tcrc_nxt[15:8] : tcrc_r[7:0];
         default: ldbyte = '0;
      endcase
      if (load) begin
         tst_nxt = ldst;
         tidx_nxt = ldidx;
         tsh_nxt = ldbyte;
         tx_pop = (ldst == PS_DATA);
         // preamble and sync stay unwhitened so the receiver can lock
         twh_nxt = ldst inside {PS_HDR, PS_LEN, PS_DATA, PS_CRC};
      end
   end

   // receive packet checker
   rph_fields_s rf;
   rph_coding_s rc;
   rph_state_e rst_r, rst_nxt, gost;
   logic s1_r, s2_r, rchip_r, rchip_nxt, rph_r, rph_nxt, rprev_r, rprev_nxt;
   logic rxv, rxb, db, go, ev_pre, ev_sync, ev_good, ev_crc;
   logic [7:0] pcnt_r, pcnt_nxt, rsh_r, rsh_nxt, rlen_r, rlen_nxt, rcnt_r, rcnt_nxt;
   logic [7:0] rhi_r, rhi_nxt, rb;
   logic [15:0] rsy_r, rsy_nxt, rcrc_r, rcrc_nxt;
   logic [8:0] rpn_r, rpn_nxt;
   logic [2:0] rbc_r, rbc_nxt;

   assign rf = RX_PH_EN ? RX_FIELDS : '0;
   assign rc = RX_PH_EN ? RX_CODING : '0;
   // manchester: first chip of each pair carries the bit
   assign rxv = bit_en & (~rc.manchester | rph_r);
   assign rxb = rc.manchester ? rchip_r : s2_r;
   assign db = rxb ^ (rc.whiten & rpn_r[0]);
   assign rb = {rsh_r[6:0], db};
   assign rx_byte = rb;

   always_comb begin
      rst_nxt = rst_r;
      rchip_nxt = rchip_r;
      rph_nxt = rph_r;
      rprev_nxt = rprev_r;
      pcnt_nxt = pcnt_r;
      rsh_nxt = rsh_r;
      rlen_nxt = rlen_r;
      rcnt_nxt = rcnt_r;
      rhi_nxt = rhi_r;
      rsy_nxt = rsy_r;
      rcrc_nxt = rcrc_r;
      rpn_nxt = rpn_r;
      rbc_nxt = rbc_r;
      go = 1'b0;
      gost = PS_IDLE;
      ev_pre = 1'b0;
      ev_sync = 1'b0;
      ev_good = 1'b0;
      ev_crc = 1'b0;
      rx_push = 1'b0;
      if (bit_en && rc.manchester) begin
         rph_nxt = ~rph_r;
         if (!rph_r) rchip_nxt = s2_r;
      end
      if (rst_r inside {PS_IDLE, PS_PRE, PS_SYNC}) begin
         rcrc_nxt = CRC_SEED;
         rpn_nxt = PN9_SEED;
         rbc_nxt = '0;
         rcnt_nxt = '0;
      end
      if (!RX_ENABLE) begin
         rst_nxt = PS_IDLE;
         rph_nxt = 1'b0;
      end else if (rst_r == PS_IDLE) begin
         go = 1'b1;
         gost = rph_fld_after(PS_IDLE, rf);
         rlen_nxt = PKT_LEN;
         pcnt_nxt = '0;
      end else if (rxv) begin
         unique case (rst_r)
            PS_PRE: begin
               rprev_nxt = rxb;
               pcnt_nxt = (rxb != rprev_r) ? 8'(pcnt_r + 1'b1) : '0;
               if (8'(pcnt_r + 1'b1) >= PRE_THRESH && rxb != rprev_r) begin
                  ev_pre = 1'b1;
                  go = 1'b1;
                  gost = rph_fld_after(PS_PRE, rf);
               end
            end
            PS_SYNC: begin
               rsy_nxt = {rsy_r[14:0], rxb};
               if ({rsy_r[14:0], rxb} == SYNC_WORD) begin
                  ev_sync = 1'b1;
                  go = 1'b1;
                  gost = rph_fld_after(PS_SYNC, rf);
               end
            end
            default: begin
               rsh_nxt = rb;
               rbc_nxt = 3'(rbc_r + 1'b1);
               if (rc.whiten) rpn_nxt = rph_pn_step(rpn_r);
               if (rst_r inside {PS_HDR, PS_LEN, PS_DATA})
                  rcrc_nxt = rph_crc_step(rcrc_r, db);
               if (rbc_r == LAST_BIT) begin
                  go = 1'b1;
                  gost = rph_fld_after(rst_r, rf);
                  unique case (rst_r)
                     PS_HDR: if (rb != HEADER_PATTERN) gost = PS_IDLE;
                     PS_LEN: rlen_nxt = rb;
                     PS_DATA: begin
                        rx_push = 1'b1;
                        rcnt_nxt = 8'(rcnt_r + 1'b1);
                        if (8'(rcnt_r + 1'b1) != rlen_r) gost = PS_DATA;
                     end
                     PS_CRC: begin
                        rhi_nxt = rb;
                        rcnt_nxt = 8'(rcnt_r + 1'b1);
                        if (rcnt_r == rlen_r) gost = PS_CRC;
                        else begin
                           gost = PS_IDLE;
                           ev_crc = ({rhi_r, rb} != rcrc_r);
                           ev_good = ({rhi_r, rb} == rcrc_r);
                        end
                     end
                     default: gost = PS_IDLE;
                  endcase
               end
            end
         endcase
      end
      if (go) begin
         if (gost == PS_DATA && rlen_nxt == '0) gost = rph_fld_after(PS_DATA, rf);
         if (gost == PS_DONE) begin
            ev_good = 1'b1;
            gost = PS_IDLE;
         end
         rst_nxt = gost;
      end
   end

   // events, sticky status and interrupt pin
   rph_events_s ev, st_r, st_nxt;
   logic tae_r, raf_r, irqn_r, irqn_nxt;
   always_comb begin
      ev = '0;
      ev.tx_aempty = TX_ALMOST_EMPTY & ~tae_r;
      ev.rx_afull = RX_ALMOST_FULL & ~raf_r;
      ev.event_a = ev_sent;
      ev.pre_valid = ev_pre;
      ev.sync_ok = ev_sync;
      ev.packet_good_flag = ev_good;
      ev.crc_err = ev_crc;
      ev.ovf_tx = tx_wr & tx_full;
      ev.ovf_rx = rx_push & rx_full;
      // a new event in the clearing cycle survives the clear
      st_nxt = (st_r & ~INT_CLEAR) | ev;
      irqn_nxt = ~|(st_nxt & INT_MASK);
   end
   assign STATUS = st_r;
   assign INTERRUPT_REQUEST_N = irqn_r;
   assign TX_BUSY = tbusy_r;
   assign TX_DATA_OUT = tout_r;

   always_ff @(posedge REF_CLK) begin
      s1_r <= RX_DATA_IN;
      s2_r <= s1_r;
      tsh_r <= tsh_nxt;
      tlen_r <= tlen_nxt;
      tcrc_r <= tcrc_nxt;
      tpn_r <= tpn_nxt;
      rsh_r <= rsh_nxt;
      rhi_r <= rhi_nxt;
      rsy_r <= rsy_nxt;
      rcrc_r <= rcrc_nxt;
      rpn_r <= rpn_nxt;
      rlen_r <= rlen_nxt;
      if (RST) begin
         div_r <= '0;
         rdata_r <= '0;
         tst_r <= PS_IDLE;
         tidx_r <= '0;
         tbc_r <= '0;
         tph_r <= 1'b0;
         twh_r <= 1'b0;
         tout_r <= 1'b0;
         tbusy_r <= 1'b0;
         rst_r <= PS_IDLE;
         rchip_r <= 1'b0;
         rph_r <= 1'b0;
         rprev_r <= 1'b0;
         pcnt_r <= '0;
         rcnt_r <= '0;
         rbc_r <= '0;
         st_r <= '0;
         tae_r <= 1'b1;
         raf_r <= 1'b1;
         irqn_r <= 1'b1;
      end else begin
         div_r <= div_nxt;
         rdata_r <= rdata_nxt;
         tst_r <= tst_nxt;
         tidx_r <= tidx_nxt;
         tbc_r <= tbc_nxt;
         tph_r <= tph_nxt;
         twh_r <= twh_nxt;
         tout_r <= tout_nxt;
         tbusy_r <= tbusy_nxt;
         rst_r <= rst_nxt;
         rchip_r <= rchip_nxt;
         rph_r <= rph_nxt;
         rprev_r <= rprev_nxt;
         pcnt_r <= pcnt_nxt;
         rcnt_r <= rcnt_nxt;
         rbc_r <= rbc_nxt;
         st_r <= st_nxt;
         tae_r <= TX_ALMOST_EMPTY;
         raf_r <= RX_ALMOST_FULL;
         irqn_r <= irqn_nxt;
      end
   end

   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (RST);

   a_tx_write_push: assert property (tx_wr && !tx_full && !tx_pop && !FIFO_RESET[FRST_TX_BIT]
      |=> tx_cnt == $past(tx_cnt) + 1'b1) else $error("tx write not stored");
   a_rx_read_pop: assert property (rx_rd && !rx_empty && !FIFO_RESET[FRST_RX_BIT]
      |=> HOST_RDATA == $past(rx_head)) else $error("rx read data wrong");
   a_fifo_reset_empty: assert property (FIFO_RESET[FRST_TX_BIT] || FIFO_RESET[FRST_RX_BIT]
      |=> (!$past(FIFO_RESET[FRST_TX_BIT]) || tx_cnt == '0)
      && (!$past(FIFO_RESET[FRST_RX_BIT]) || rx_cnt == '0)) else $error("fifo not reset");
   a_afull_enough: assert property ($rose(st_r.rx_afull) && $stable(RX_AF_LEVEL)
      |-> $past(rx_cnt) >= RX_AF_LEVEL) else $error("rx almost full too early");
   a_tx_ovf_flag: assert property (tx_wr && tx_full
      |=> st_r.ovf_tx && tx_cnt <= $past(tx_cnt)) else $error("tx overflow missed");
   a_irq_pin_level: assert property (INTERRUPT_REQUEST_N == !(|(st_r & $past(INT_MASK))))
      else $error("interrupt pin mismatch");
   a_sent_then_idle: assert property (tst_r == PS_DONE
      |=> tst_r == PS_IDLE && st_r.event_a && !TX_BUSY) else $error("tx did not idle");
   a_tx_preamble: assert property (tst_r == PS_IDLE && TX_START && tf.preamble
      |=> tst_r == PS_PRE && tsh_r == PREAMBLE_BYTE) else $error("no preamble");
   a_sync_flag: assert property (rst_r == PS_SYNC && rxv && RX_ENABLE
      && {rsy_r[14:0], rxb} == SYNC_WORD |=> st_r.sync_ok) else $error("sync not flagged");
   a_tx_aempty_evt: assert property ($rose(TX_ALMOST_EMPTY) |=> st_r.tx_aempty)
      else $error("tx almost empty missed");
   a_crc_verdict: assert property (ev_crc |-> !ev_good ##1 st_r.crc_err)
      else $error("crc verdict wrong");

   c_event_a: cover property (tst_r == PS_CRC ##[1:1000] st_r.event_a);
   c_packet_good: cover property (ev_good);
   c_crc_error: cover property (ev_crc);
   c_rx_overflow: cover property (ev.ovf_rx);
endmodule

// >>> rph_air_model.sv
`timescale 1ns/1ps
module rph_air_model (
   input wire logic clk,
   input wire logic tx_bit,
   input wire logic corrupt,
   output logic rx_bit
);
   // one clock of flight time; bits go wrong only while the bench asks
   always_ff @(posedge clk) begin
      rx_bit <= tx_bit ^ corrupt;
   end
endmodule

// >>> rph_top_bench.sv
`timescale 1ns/1ps
module rph_top_bench;
   import rph_pkg::*;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic host_wr = 1'b0, host_rd = 1'b0, tx_start = 1'b0, rx_enable = 1'b0;
   logic corrupt = 1'b0, ph_en = 1'b1, rd_d = 1'b0;
   logic [7:0] host_addr = 8'h00, host_wdata = 8'h00, host_rdata;
   logic [1:0] fifo_reset = 2'h0;
   logic [6:0] tx_lvl = 7'h02, rx_lvl = 7'h04, tx_count, rx_count;
   logic tx_ae, rx_af, tx_busy, tx_bit, rx_bit, irq_n;
   rph_fields_s fields = 5'h1f;
   logic [7:0] hdr = 8'h5a;
   rph_coding_s coding = 2'h0;
   rph_events_s status, int_mask = 9'h022, int_clear = 9'h000;
   int n_errors = 0, check_count = 0, seed = 49704;
   logic [7:0] exp_q[$];
   logic [7:0] pay[4];

   always #10 ref_clk = ~ref_clk;

   rph_top #(.BIT_DIV(4)) dut_u (.REF_CLK(ref_clk), .RST(rst), .HOST_WR(host_wr),
      .HOST_RD(host_rd), .HOST_ADDR(host_addr), .HOST_WDATA(host_wdata),
      .HOST_RDATA(host_rdata), .FIFO_RESET(fifo_reset), .TX_AE_LEVEL(tx_lvl),
      .RX_AF_LEVEL(rx_lvl), .TX_COUNT(tx_count), .RX_COUNT(rx_count),
      .TX_ALMOST_EMPTY(tx_ae), .RX_ALMOST_FULL(rx_af), .TX_PH_EN(ph_en), .RX_PH_EN(ph_en),
      .TX_FIELDS(fields), .RX_FIELDS(fields), .TX_CODING(coding), .RX_CODING(coding),
      .SYNC_WORD(16'h2dd4), .HEADER_PATTERN(hdr), .PRE_THRESH(8'h08),
      .PRE_BYTES(8'h04), .PKT_LEN(8'h04), .TX_START(tx_start), .TX_BUSY(tx_busy),
      .TX_DATA_OUT(tx_bit), .RX_ENABLE(rx_enable), .RX_DATA_IN(rx_bit), .STATUS(status),
      .INT_MASK(int_mask), .INT_CLEAR(int_clear), .INTERRUPT_REQUEST_N(irq_n));

   rph_air_model air_u (.clk(ref_clk), .tx_bit(tx_bit), .corrupt(corrupt), .rx_bit(rx_bit));

   task automatic final_report();
      if (n_errors == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask

   // popped bytes appear one cycle after the accepted read
   always @(posedge ref_clk) begin
      if (rd_d) begin
         chk("host_rdata", {8'h00, exp_q.pop_front()}, {8'h00, host_rdata});
      end
      rd_d <= host_rd && host_addr == CMD_RX_READ && rx_count != 0;
   end

   task automatic cmd(logic wr, logic [7:0] addr, logic [7:0] data);
      @(posedge ref_clk);
      host_wr <= wr;
      host_rd <= !wr;
      host_addr <= addr;
      host_wdata <= data;
      @(posedge ref_clk);
      host_wr <= 1'b0;
      host_rd <= 1'b0;
   endtask

   task automatic pulse(logic [1:0] fr, logic [8:0] clr);
      @(posedge ref_clk);
      fifo_reset <= fr;
      int_clear <= clr;
      @(posedge ref_clk);
      fifo_reset <= 2'h0;
      int_clear <= 9'h000;
      repeat (3) @(posedge ref_clk);
      #1;
   endtask

   task automatic send(logic [1:0] cod, logic bad);
      int n;
      coding <= cod;
      hdr <= 8'($random(seed));
      for (int i = 0; i < 4; i++) begin
         pay[i] = 8'($random(seed));
         cmd(1'b1, CMD_TX_WRITE, pay[i]);
      end
      @(posedge ref_clk);
      tx_start <= 1'b1;
      if (cod[0]) rx_enable <= 1'b0;
      @(posedge ref_clk);
      tx_start <= 1'b0;
      if (cod[0]) begin
         // chip pairs never resync: wake the receiver after the first bit tick of the frame
         #1;
         n = 0;
         while (!dut_u.bit_en && n < 8) begin
            @(posedge ref_clk);
            #1;
            n++;
         end
         if (n >= 8) begin
            n_errors++;
            final_report();
         end
         @(posedge ref_clk);
         rx_enable <= 1'b1;
      end
      if (bad) begin
         // lands inside the first payload byte, past the header and length bytes
         repeat (272) @(posedge ref_clk);
         corrupt <= 1'b1;
         repeat (8) @(posedge ref_clk);
         corrupt <= 1'b0;
      end
      n = 0;
      while ((tx_busy || !(status.packet_good_flag || status.crc_err)) && n < 4000) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      if (n >= 4000) begin
         n_errors++;
         final_report();
      end
      repeat (4) @(posedge ref_clk);
      #1;
      chk("tx_count", 16'h0, 16'(tx_count));
      chk("event_a", 16'h1, 16'(status.event_a));
      chk("tx_aempty", 16'h1, 16'(status.tx_aempty));
      chk("crc_err", 16'(bad), 16'(status.crc_err));
      chk("packet_good", 16'(!bad), 16'(status.packet_good_flag));
      chk("rx_count", 16'h4, 16'(rx_count));
      chk("rx_afull", 16'h1, 16'(rx_af && status.rx_afull));
      chk("irq_n", 16'h0, 16'(irq_n));
      if (bad) begin
         pulse(2'h2, 9'h000);
         chk("rx_count", 16'h0, 16'(rx_count));
      end else begin
         for (int i = 0; i < 4; i++) begin
            exp_q.push_back(pay[i]);
            cmd(1'b0, CMD_RX_READ, 8'h00);
         end
      end
      pulse(2'h0, 9'h1ff);
      chk("irq_n", 16'h1, 16'(irq_n));
   endtask

   initial begin
      repeat (12) @(posedge ref_clk);
      rst <= 1'b0;
      rx_enable <= 1'b1;
      @(posedge ref_clk);
      #1;
      chk("irq_n", 16'h1, 16'(irq_n));
      chk("status", 16'h0, 16'(status));
      cmd(1'b1, 8'h55, 8'h12);
      cmd(1'b0, 8'h66, 8'h00);
      repeat (2) @(posedge ref_clk);
      #1;
      chk("tx_count", 16'h0, 16'(tx_count));
      send(2'h0, 1'b0);
      send(2'h2, 1'b0);
      send(2'h3, 1'b0);
      send(2'h0, 1'b1);
      for (int i = 0; i < 65; i++) begin
         cmd(1'b1, CMD_TX_WRITE, 8'($random(seed)));
      end
      repeat (2) @(posedge ref_clk);
      #1;
      chk("tx_count", 16'd64, 16'(tx_count));
      chk("ovf_tx", 16'h1, 16'(status.ovf_tx));
      pulse(2'h1, 9'h1ff);
      chk("tx_count", 16'h0, 16'(tx_count));
      final_report();
   end
endmodule
